//--- rtl/spepc_ctrl.sv
// What this block does
// - program needs unlock latch set beforehand
// - locked program ignored until next select fall
// - select rise after whole byte starts program
// - only status read accepted while programming
// - status bit zero shows busy cycle
// - only six low address bits increment
// - over 64 bytes keeps last 64
// - short program touches only addressed bytes
// - program start clears unlock latch
// - page erase ignores low six bits
// - page erase needs unlock latch set
// - two chip erase opcodes, no address
// - chip erase needs unlock latch set
// - sleep mode accepts only wake
// - wake acts on eighth rising clock edge
// - wake recovery of 75 us before ready
// - partial byte frame keeps unlock latch
// - latch cleared at reset and listed commands
//
// Purpose: spi command decoder in front of a self-timed program engine
// Assumes: spi mode 0, msb first; engine reports done as one-cycle pulse
// Notes:   pins are sampled by clk through two flops before use
`timescale 1ns/1ps
`include "spepc_cfg.svh"

module spepc_ctrl #(
  parameter int WAKE_CYCLES = `SPEPC_WAKE_CYCLES
) (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      reset,
  // spi pins
  input  wire logic                      spi_cs_n,
  input  wire logic                      spi_sck,
  input  wire logic                      spi_sdi,
  output logic                           spi_sdo,
  // page buffer write stream toward the engine
  output spepc_pkg::spepc_word_type      buf_word,
  output logic                           buf_valid,
  input  wire logic                      buf_ready,
  // buffer clear once a program frame's second address byte is in
  output logic                           buf_clear,
  // engine start and completion
  output spepc_pkg::spepc_start_type     eng_start,
  output logic                           eng_start_valid,
  input  wire logic                      eng_done,
  // state views
  output logic                           busy_cycle_flag,
  output logic                           program_unlock_latch,
  output logic                           sleeping,
  output logic                           ready_for_commands
);
  import spepc_pkg::*;

  typedef enum logic [2:0] {
    ST_OPCODE, ST_ADDR_HI, ST_ADDR_LO, ST_DATA, ST_STATUS, ST_IGNORE,
    ST_REFUSED
  } spepc_state_type;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers; first stage feeds only the second
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic [2:0] sync3_r;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync1_r <= 3'h4;   // idle pins: select high, sck low
      sync2_r <= 3'h4;
      sync3_r <= 3'h4;
    end else begin
      sync1_r <= {spi_cs_n, spi_sck, spi_sdi};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  logic cs_n_s;
  logic sdi_s;
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;
  assign cs_n_s   = sync2_r[2];
  assign sdi_s    = sync2_r[0];
  assign sck_rise = sync2_r[1] & ~sync3_r[1] & ~cs_n_s;
  assign sck_fall = ~sync2_r[1] & sync3_r[1] & ~cs_n_s;
  assign cs_fall  = ~sync2_r[2] & sync3_r[2];
  assign cs_rise  = sync2_r[2] & ~sync3_r[2];

  ////////////////////////////////////////////////////////////////////////
  // bit shifter and byte framing
  logic [2:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic       byte_done;
  logic [7:0] byte_val;
  assign byte_done = sck_rise && (bit_cnt_r == 3'h7);
  assign byte_val  = {shift_r[6:0], sdi_s};

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bit_cnt_r <= 3'h0;
      shift_r   <= 8'h00;
    end else if (cs_fall) begin
      bit_cnt_r <= 3'h0;
    end else if (sck_rise) begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
      shift_r   <= byte_val;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // command state
  spepc_state_type state_r;
  logic [7:0]  op_r;
  logic [14:0] addr_r;
  logic        whole_r;   // frame ended on a byte boundary
  logic        got_data_r;
  logic        busy_r;
  logic        sleep_r;
  localparam int WAKE_W = $clog2(WAKE_CYCLES + 1);
  logic [WAKE_W-1:0] wake_cnt_r;
  logic        waking;
  assign waking = (wake_cnt_r != '0);

  // opcode acceptance gate while busy, asleep or recovering
  function automatic logic op_allowed(input logic [7:0] op,
                                      input logic b, input logic s,
                                      input logic w);
    logic ok;
    ok = 1'b1;
    if (s) ok = (op == `SPEPC_OP_WAKE);
    else if (b) ok = (op == `SPEPC_OP_STATUS);
    else if (w) ok = 1'b0;
    return ok;
  endfunction

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_r    <= ST_OPCODE;
      op_r       <= 8'h00;
      addr_r     <= 15'h0000;
      whole_r    <= 1'b1;
      got_data_r <= 1'b0;
    end else if (cs_fall) begin
      state_r    <= ST_OPCODE;   // fresh frame after every fall
      whole_r    <= 1'b1;
      got_data_r <= 1'b0;
    end else if (sck_rise) begin
      whole_r <= (bit_cnt_r == 3'h7);
      if (byte_done) begin
        case (state_r)
          ST_OPCODE: begin
            op_r <= byte_val;
            // refused frames stay dead even if busy ends before select
            if (!op_allowed(byte_val, busy_r, sleep_r, waking))
              state_r <= ST_REFUSED;
            else if (byte_val == `SPEPC_OP_STATUS)
              state_r <= ST_STATUS;
            else if (byte_val == `SPEPC_OP_PROGRAM ||
                     byte_val == `SPEPC_OP_PAGE_ERASE)
              state_r <= program_unlock_latch ? ST_ADDR_HI
                                              : ST_REFUSED;
            else
              state_r <= ST_IGNORE;  // single-byte commands end here
          end
          ST_ADDR_HI: begin
            addr_r[14:8] <= byte_val[6:0];  // top bit dropped
            state_r      <= ST_ADDR_LO;
          end
          ST_ADDR_LO: begin
            addr_r[7:0] <= byte_val;
            state_r     <= (op_r == `SPEPC_OP_PROGRAM) ? ST_DATA : ST_IGNORE;
          end
          ST_DATA: begin
            got_data_r  <= 1'b1;
            addr_r[5:0] <= addr_r[5:0] + 6'h01;
          end
          ST_STATUS: state_r <= ST_STATUS;
          ST_IGNORE: state_r <= ST_IGNORE;
          ST_REFUSED: state_r <= ST_REFUSED;
          default:   state_r <= ST_OPCODE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // frame end decoding
  logic frame_ok;
  logic is_chip;
  logic do_prog;
  logic do_page;
  logic do_chip;
  logic do_sleep;
  logic do_lock;
  assign frame_ok = cs_rise && whole_r && !busy_r && !sleep_r;
  assign is_chip  = (op_r == `SPEPC_OP_CHIP_ERASE0) ||
                    (op_r == `SPEPC_OP_CHIP_ERASE1);
  assign do_prog  = frame_ok && state_r == ST_DATA && got_data_r &&
                    program_unlock_latch;
  assign do_page  = frame_ok && state_r == ST_IGNORE && program_unlock_latch
                    && op_r == `SPEPC_OP_PAGE_ERASE;
  assign do_chip  = frame_ok && state_r == ST_IGNORE && !waking &&
                    program_unlock_latch && is_chip;
  assign do_sleep = frame_ok && state_r == ST_IGNORE && !waking &&
                    op_r == `SPEPC_OP_SLEEP;
  assign do_lock  = frame_ok && state_r == ST_IGNORE && !waking &&
                    op_r == `SPEPC_OP_LOCK;
  logic do_unlock;
  assign do_unlock = frame_ok && state_r == ST_IGNORE && !waking &&
                     op_r == `SPEPC_OP_UNLOCK;
  logic op_started;
  assign op_started = ~(state_r == ST_OPCODE);

  // unlock latch: reset clears; listed commands clear on success
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      program_unlock_latch <= 1'b0;
    end else if (do_prog || do_page || do_chip || do_sleep || do_lock) begin
      program_unlock_latch <= 1'b0;
    end else if (do_unlock && op_started) begin
      program_unlock_latch <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // busy flag and engine start
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      busy_r          <= 1'b0;
      eng_start_valid <= 1'b0;
      eng_start       <= '0;
    end else begin
      eng_start_valid <= do_prog || do_page || do_chip;
      if (do_prog)
        eng_start <= '{job: SPEPC_JOB_PROGRAM, addr: addr_r};
      else if (do_page)
        eng_start <= '{job: SPEPC_JOB_PAGE_ERASE,
                       addr: {addr_r[14:6], 6'h00}};
      else if (do_chip)
        eng_start <= '{job: SPEPC_JOB_CHIP_ERASE, addr: 15'h0000};
      if (do_prog || do_page || do_chip)
        busy_r <= 1'b1;
      else if (eng_done)
        busy_r <= 1'b0;
    end
  end
  assign busy_cycle_flag = busy_r;

  ////////////////////////////////////////////////////////////////////////
  // sleep and wake recovery
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sleep_r    <= 1'b0;
      wake_cnt_r <= '0;
    end else if (do_sleep) begin
      sleep_r <= 1'b1;
    end else if (sleep_r && byte_done && state_r == ST_OPCODE &&
                 byte_val == `SPEPC_OP_WAKE) begin
      sleep_r    <= 1'b0;
      wake_cnt_r <= WAKE_W'(WAKE_CYCLES);
    end else if (waking) begin
      wake_cnt_r <= wake_cnt_r - WAKE_W'(1);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sleeping           <= 1'b0;
      ready_for_commands <= 1'b1;
    end else begin
      sleeping           <= sleep_r;
      ready_for_commands <= !sleep_r && !waking;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status output: busy bit shifted msb first on falling clock
  logic [7:0] sdo_sh_r;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sdo_sh_r <= 8'h00;
      spi_sdo  <= 1'b0;
    end else if (state_r == ST_STATUS) begin
      if (sck_fall) begin
        spi_sdo  <= sdo_sh_r[7];
        sdo_sh_r <= {sdo_sh_r[6:0], 1'b0};
        if (bit_cnt_r == 3'h0)
          spi_sdo <= 1'b0;  // msb of a fresh status byte
        if (bit_cnt_r == 3'h0)
          sdo_sh_r <= {5'h00, program_unlock_latch, busy_r, 1'b0};
      end
    end else begin
      spi_sdo  <= 1'b0;
      sdo_sh_r <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // two-entry buffer toward the page buffer; last write wins per offset
  logic           skid_valid_r;
  spepc_word_type skid_word_r;
  spepc_word_type new_word;
  logic           push;
  logic           pop;
  assign new_word = '{offset: addr_r[5:0], data: byte_val};
  assign push     = byte_done && state_r == ST_DATA && !skid_valid_r;
  assign pop      = buf_valid && buf_ready;

  // output stage plus one skid entry, so the outputs leave flops;
  // a full buffer drops the word; host sck is slow versus clk
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      buf_valid    <= 1'b0;
      buf_word     <= '0;
      skid_valid_r <= 1'b0;
      skid_word_r  <= '0;
    end else if (pop || !buf_valid) begin
      if (skid_valid_r) begin
        buf_valid    <= 1'b1;
        buf_word     <= skid_word_r;
        skid_valid_r <= 1'b0;
      end else begin
        buf_valid <= push;
        if (push)
          buf_word <= new_word;
      end
    end else if (push) begin
      skid_valid_r <= 1'b1;
      skid_word_r  <= new_word;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      buf_clear <= 1'b0;
    end else begin
      buf_clear <= byte_done && state_r == ST_ADDR_LO &&
                   op_r == `SPEPC_OP_PROGRAM;
    end
  end

endmodule

//--- rtl/spepc_cfg.svh
// Purpose: constants for the serial program/erase command block
// Assumes: included by bare name
// Notes:   every opcode, chip erase and wake included, is a plain define here
`ifndef SPEPC_CFG_SVH
`define SPEPC_CFG_SVH
`define SPEPC_OP_UNLOCK      8'h06
`define SPEPC_OP_LOCK        8'h04
`define SPEPC_OP_STATUS      8'h05
`define SPEPC_OP_PROGRAM     8'h02
`define SPEPC_OP_PAGE_ERASE  8'h42
`define SPEPC_OP_CHIP_ERASE0 8'h60
`define SPEPC_OP_CHIP_ERASE1 8'hc7
`define SPEPC_OP_SLEEP       8'hb9
`define SPEPC_OP_WAKE        8'hab
`define SPEPC_BUSY_BIT       0
`define SPEPC_PAGE_BYTES     64
`define SPEPC_WAKE_US        75
`define SPEPC_CLK_MHZ        125
`define SPEPC_WAKE_CYCLES    (`SPEPC_WAKE_US * `SPEPC_CLK_MHZ)
`endif

//--- rtl/spepc_pkg.sv
// Purpose: types for the serial program/erase command block
// Assumes: constants come from spepc_cfg.svh
// Notes:   none
package spepc_pkg;
  typedef enum logic [1:0] {
    SPEPC_JOB_PROGRAM,
    SPEPC_JOB_PAGE_ERASE,
    SPEPC_JOB_CHIP_ERASE
  } spepc_job_type;

  // one write-buffer word toward the engine
  typedef struct packed {
    logic [5:0] offset;
    logic [7:0] data;
  } spepc_word_type;

  // job start request toward the engine
  typedef struct packed {
    spepc_job_type job;
    logic [14:0]   addr;
  } spepc_start_type;
endpackage

//--- testbench/spepc_ctrl_sva.sv
// Purpose: port assertions for the serial command block
// Assumes: sees only the top ports, one clock domain
// Notes:   WAKE_CYCLES must match the bound instance
`timescale 1ns/1ps
module spepc_ctrl_sva #(
  parameter int WAKE_CYCLES = 20
) (
  // clock and reset
  input wire logic                   clk,
  input wire logic                   reset,
  // engine side
  input wire spepc_pkg::spepc_start_type eng_start,
  input wire logic                   eng_start_valid,
  input wire logic                   eng_done,
  // state views
  input wire logic                   busy_cycle_flag,
  input wire logic                   program_unlock_latch,
  input wire logic                   sleeping,
  input wire logic                   ready_for_commands
);
  import spepc_pkg::*;
  // slack covers the pin synchroniser delay
  localparam int WAKE_MAX = WAKE_CYCLES + 8;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////
  property p_start_pulse;
    eng_start_valid |=> !eng_start_valid && $stable(eng_start);
  endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("start pulse longer than one cycle");
  property p_start_latch;
    eng_start_valid |-> $past(program_unlock_latch);
  endproperty
  a_start_latch: assert property (p_start_latch)
    else $error("start without unlock latch");
  property p_start_effects;
    eng_start_valid |=> !program_unlock_latch && busy_cycle_flag;
  endproperty
  a_start_effects: assert property (p_start_effects)
    else $error("start did not set busy or clear latch");
  property p_busy_holds;
    busy_cycle_flag && !eng_done |=> busy_cycle_flag;
  endproperty
  a_busy_holds: assert property (p_busy_holds)
    else $error("busy dropped before done");
  property p_done_ends;
    busy_cycle_flag && eng_done |=> !busy_cycle_flag;
  endproperty
  a_done_ends: assert property (p_done_ends)
    else $error("busy stuck after done");
  property p_no_start_busy;
    busy_cycle_flag && !eng_done |=> !eng_start_valid;
  endproperty
  a_no_start_busy: assert property (p_no_start_busy)
    else $error("start while busy");
  property p_sleep_quiet;
    sleeping |-> !eng_start_valid && !program_unlock_latch;
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet)
    else $error("activity while sleeping");
  property p_wake_recover;
    $fell(sleeping) |=> !ready_for_commands[*8]
      ##[1:WAKE_MAX] ready_for_commands;
  endproperty
  a_wake_recover: assert property (p_wake_recover)
    else $error("wake recovery window wrong");
endmodule

bind spepc_ctrl spepc_ctrl_sva #(.WAKE_CYCLES(WAKE_CYCLES)) u_sva (
  .clk(clk), .reset(reset), .eng_start(eng_start),
  .eng_start_valid(eng_start_valid), .eng_done(eng_done),
  .busy_cycle_flag(busy_cycle_flag),
  .program_unlock_latch(program_unlock_latch),
  .sleeping(sleeping), .ready_for_commands(ready_for_commands));

//--- testbench/spepc_host_model.sv
// Purpose: spi host that frames commands into the block
// Assumes: mode 0, msb first, 80 ns sck period
// Notes:   sck stands low and sdi flips once cs is released
`timescale 1ns/1ps
module spepc_host_model (
  // bench clock; pins move only on its rising edge
  input  wire logic clk,
  // spi pins
  output logic      spi_cs_n,
  output logic      spi_sck,
  output logic      spi_sdi,
  input  wire logic spi_sdo
);
  // idle bus at time zero
  initial begin
    spi_cs_n = 1'b1;
    spi_sck  = 1'b0;
    spi_sdi  = 1'b0;
  end
  // one frame; nbits below a byte multiple gives a partial frame;
  // each sck phase is 5 clk, giving the 80 ns sck period
  task automatic xfer(input logic [7:0] q[$], input int nbits,
                      output logic [7:0] rx);
    rx = 8'h00;
    @(posedge clk);
    spi_cs_n <= 1'b0;
    for (int i = 0; i < nbits; i++) begin
      spi_sdi <= q[i/8][7-(i%8)];
      repeat (5) @(posedge clk);
      spi_sck <= 1'b1;
      rx = {rx[6:0], spi_sdo};
      repeat (5) @(posedge clk);
      spi_sck <= 1'b0;
    end
    // select rises in the sck low phase after the last bit
    repeat (2) @(posedge clk);
    spi_cs_n <= 1'b1;
    spi_sdi  <= ~spi_sdi;
    // gap lets the frame end pass the pin synchroniser
    repeat (50) @(posedge clk);
  endtask
endmodule

//--- testbench/spepc_ctrl_tb_top.sv
// Purpose: self-checking bench for the serial command block
// Assumes: host model drives pins, bench stands in for the engine
// Notes:   buffer stall limited to two words, the buffer depth
`timescale 1ns/1ps
`include "spepc_cfg.svh"
module spepc_ctrl_tb_top;
  import spepc_pkg::*;
  logic           clk, reset, buf_ready, eng_done, buf_valid, buf_clear;
  logic           spi_cs_n, spi_sck, spi_sdi, spi_sdo, eng_start_valid;
  logic           busy_cycle_flag, program_unlock_latch;
  logic           sleeping, ready_for_commands;
  spepc_word_type  buf_word;
  spepc_start_type eng_start;
  logic [7:0]     mem [64];
  logic [7:0]     rx;
  logic [7:0]     q [$];
  int             fail_count, samples_checked, ns, nclr;
  // recovery long enough to land a frame inside it
  localparam int  WAKE_SIM = 200;
  spepc_ctrl #(.WAKE_CYCLES(WAKE_SIM)) DUT (.clk(clk), .reset(reset),
    .spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .spi_sdi(spi_sdi),
    .spi_sdo(spi_sdo), .buf_word(buf_word), .buf_valid(buf_valid),
    .buf_ready(buf_ready), .buf_clear(buf_clear),
    .eng_start(eng_start), .eng_start_valid(eng_start_valid),
    .eng_done(eng_done), .busy_cycle_flag(busy_cycle_flag),
    .program_unlock_latch(program_unlock_latch), .sleeping(sleeping),
    .ready_for_commands(ready_for_commands));
  spepc_host_model host (.clk(clk), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck),
    .spi_sdi(spi_sdi), .spi_sdo(spi_sdo));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // engine stand-in: page image and start count
  always @(posedge clk) begin
    if (buf_valid && buf_ready) mem[buf_word.offset] <= buf_word.data;
    if (eng_start_valid) ns <= ns + 1;
    if (buf_clear) nclr <= nclr + 1;
  end
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    samples_checked++;
    if (e !== s) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cmd(input logic [7:0] c[$]);
    host.xfer(c, c.size() * 8, rx);
  endtask
  task automatic stat();
    host.xfer('{`SPEPC_OP_STATUS, 8'h00}, 16, rx);
  endtask
  task automatic done();
    @(posedge clk) eng_done <= 1'b1;
    @(posedge clk) eng_done <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_locked();
    int n0 = ns;
    cmd('{`SPEPC_OP_PROGRAM, 8'h00, 8'h10, 8'h55});
    chk("starts", n0, ns);
    chk("busy", 0, busy_cycle_flag);
    cmd('{`SPEPC_OP_UNLOCK});
    chk("latch", 1, program_unlock_latch);
    $display("test locked_program done");
  endtask
  task automatic t_program();
    int n0 = ns;
    int c0 = nclr;
    for (int i = 0; i < 64; i++) mem[i] = 8'hee;
    @(posedge clk) buf_ready <= 1'b0;
    cmd('{`SPEPC_OP_PROGRAM, 8'h12, 8'h3f, 8'ha1, 8'ha2});
    chk("starts", n0 + 1, ns);
    chk("job", SPEPC_JOB_PROGRAM, eng_start.job);
    chk("page", 15'h123f >> 6, eng_start.addr >> 6);
    chk("latch", 0, program_unlock_latch);
    chk("clears", c0 + 1, nclr);
    stat();
    chk("status busy", 1, rx[`SPEPC_BUSY_BIT]);
    cmd('{`SPEPC_OP_UNLOCK});
    chk("latch busy", 0, program_unlock_latch);
    @(posedge clk) buf_ready <= 1'b1;
    repeat (10) @(posedge clk);
    chk("byte 3f", 8'ha1, mem[6'h3f]);
    chk("byte 00", 8'ha2, mem[6'h00]);
    chk("byte 3e", 8'hee, mem[6'h3e]);
    done();
    stat();
    chk("status idle", 0, rx[`SPEPC_BUSY_BIT]);
    $display("test program_wrap done");
  endtask
  task automatic t_over64();
    cmd('{`SPEPC_OP_UNLOCK});
    q = '{`SPEPC_OP_PROGRAM, 8'h00, 8'h00};
    for (int i = 1; i <= 66; i++) q.push_back(8'(i));
    cmd(q);
    done();
    chk("byte 00", 8'd65, mem[0]);
    chk("byte 01", 8'd66, mem[1]);
    chk("byte 02", 8'd3, mem[2]);
    $display("test over64 done");
  endtask
  task automatic t_erase();
    logic [7:0] ops [3] = '{`SPEPC_OP_PAGE_ERASE, `SPEPC_OP_CHIP_ERASE0,
                            `SPEPC_OP_CHIP_ERASE1};
    int n0 = ns;
    cmd('{`SPEPC_OP_CHIP_ERASE0});
    chk("locked erase", n0, ns);
    for (int k = 0; k < 3; k++) begin
      cmd('{`SPEPC_OP_UNLOCK});
      q = '{ops[k]};
      if (k == 0) q = '{ops[0], 8'h2a, 8'h7f};
      cmd(q);
      chk("starts", n0 + k + 1, ns);
      chk("job", (k == 0) ? SPEPC_JOB_PAGE_ERASE : SPEPC_JOB_CHIP_ERASE,
          eng_start.job);
      if (k == 0) chk("page", 15'h2a7f >> 6, eng_start.addr >> 6);
      stat();
      chk("status busy", 1, rx[`SPEPC_BUSY_BIT]);
      done();
    end
    // refused sleep must stay dead when busy ends mid-frame
    cmd('{`SPEPC_OP_UNLOCK});
    cmd('{`SPEPC_OP_CHIP_ERASE1});
    fork
      cmd('{`SPEPC_OP_SLEEP, 8'h00});
      begin
        repeat (120) @(posedge clk);
        done();
      end
    join
    chk("sleep while busy", 0, sleeping);
    $display("test erase done");
  endtask
  task automatic t_partial();
    cmd('{`SPEPC_OP_UNLOCK});
    host.xfer('{`SPEPC_OP_LOCK}, 5, rx);
    chk("latch partial", 1, program_unlock_latch);
    cmd('{`SPEPC_OP_LOCK});
    chk("latch lock", 0, program_unlock_latch);
    $display("test partial done");
  endtask
  task automatic t_sleep();
    cmd('{`SPEPC_OP_UNLOCK});
    cmd('{`SPEPC_OP_SLEEP});
    chk("sleeping", 1, sleeping);
    chk("latch", 0, program_unlock_latch);
    cmd('{`SPEPC_OP_UNLOCK});
    chk("latch asleep", 0, program_unlock_latch);
    cmd('{`SPEPC_OP_WAKE});
    chk("awake", 0, sleeping);
    chk("recovering", 0, ready_for_commands);
    cmd('{`SPEPC_OP_UNLOCK});
    chk("latch recovering", 0, program_unlock_latch);
    repeat (WAKE_SIM) @(posedge clk);
    chk("ready", 1, ready_for_commands);
    cmd('{`SPEPC_OP_UNLOCK});
    chk("latch awake", 1, program_unlock_latch);
    $display("test sleep done");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // main sequence
  initial begin
    reset = 1'b1;
    buf_ready = 1'b1;
    eng_done = 1'b0;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    repeat (5) @(posedge clk);
    t_locked();
    t_program();
    t_over64();
    t_erase();
    t_partial();
    t_sleep();
    tally_and_finish();
  end
  // watchdog well past the expected run of about 87 us
  initial begin
    #400us;
    fail_count++;
    tally_and_finish();
  end
endmodule
